/* File: rtl/led_pwm_register_bank.sv */
// Notes on behaviour
// - Offset 00h bit D0 is the software shutdown control; register resets to zero.
// - Offsets 05h-20h hold 28 eight-bit duty values, default zero.
// - Output is active for duty/256 of each PWM period.
// - Duty and control writes are held; writing 00h to 25h commits them.
// - Offsets 2Ah-45h hold channel control; bit D0 turns output on.
// - Control bits D2:D1 scale current: full, half, third, quarter.
// - Registers ordered by channel: channel one at 2Ah and 05h.
// - Offset 4Ah bit D0 is the global gate; register resets to zero.
// - Offset 4Bh bit D0 picks PWM rate: zero 3kHz default, one 22kHz.
// - Writing 00h to 4Fh returns every register to its default.
// - At power-up every register holds its default, outputs dark.
// - Only write addresses 01111 plus two strap bits are answered; no reads.
// - Address, offset, data bytes go MSB first, each acknowledged by device.
// - Register pointer advances by one after each acknowledged data byte.
`include "led_pwm_regs.svh"

module led_pwm_register_bank
   import led_pwm_pkg::*;
(
   // Clock and reset.
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Serial port pins and address strap.
   input  wire serial_in_t             serialIn,
   output logic                        sdaOut,
   output logic                        sdaOe,
   input  wire logic [1:0]             addrStrap,
   // LED channel outputs.
   output logic [`CHANNELS-1:0]        chanOut,
   output logic [`CHANNELS-1:0][1:0]   chanScale
);

   localparam logic [7:0] SLOW_DIV = 8'(`PWM_SLOW_DIV);
   localparam logic [7:0] FAST_DIV = 8'(`PWM_FAST_DIV);

   rx_state_t   state_r;
   logic        sclPrev_r;
   logic        sdaPrev_r;
   logic [3:0]  bitCnt_r;
   logic [1:0]  byteIdx_r;
   logic [7:0]  shift_r;
   logic [7:0]  ptr_r;
   logic        shutNormal_r;
   logic        gateOff_r;
   logic        freqFast_r;
   logic [7:0]  divCnt_r;
   logic [7:0]  phase_r;
   logic [7:0]  holdDuty [`CHANNELS];
   logic [7:0]  actDuty  [`CHANNELS];
   chan_ctrl_t  holdCtrl [`CHANNELS];
   chan_ctrl_t  actCtrl  [`CHANNELS];

   logic        sclRise;
   logic        sclFall;
   logic        startSeen;
   logic        stopSeen;
   logic        byteDone;
   logic        addrMatch;
   logic        wrStb;
   logic        commit;
   logic        swReset;
   logic        regClear;
   logic        tick;
   logic [`CHANNELS-1:0] chanOut_nxt;

   // Edge and bus condition detection on the sampled pins.
   assign sclRise   = serialIn.scl & ~sclPrev_r;
   assign sclFall   = ~serialIn.scl & sclPrev_r;
   assign startSeen = serialIn.scl & sclPrev_r & sdaPrev_r & ~serialIn.sda;
   assign stopSeen  = serialIn.scl & sclPrev_r & ~sdaPrev_r & serialIn.sda;
   assign byteDone  = (state_r == S_RECV) && sclFall && (bitCnt_r == 4'd8);
   assign addrMatch = (shift_r == {`SLAVE_ADDR_HI, addrStrap, `WRITE_FLAG});
   assign wrStb     = byteDone && (byteIdx_r == 2'd2);
   assign commit    = wrStb && (ptr_r == `OFF_COMMIT) && (shift_r == `TRIGGER_BYTE);
   assign swReset   = wrStb && (ptr_r == `OFF_SOFT_RESET) && (shift_r == `TRIGGER_BYTE);
   assign regClear  = reset | swReset;

   // Pin history for edge detection.
   always_ff @(posedge clk) begin
      if (reset) begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclPrev_r <= serialIn.scl;
         sdaPrev_r <= serialIn.sda;
      end
   end

   // Byte receiver: start, shift on rising clock, acknowledge after each byte unless the address byte does not match.
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r   <= S_IDLE;
         bitCnt_r  <= 4'd0;
         byteIdx_r <= 2'd0;
         shift_r   <= 8'h00;
      end else if (stopSeen) begin
         state_r <= S_IDLE;
      end else if (startSeen) begin
         state_r   <= S_RECV;
         bitCnt_r  <= 4'd0;
         byteIdx_r <= 2'd0;
      end else begin
         case (state_r)
            S_RECV: begin
               if (sclRise) begin
                  shift_r  <= {shift_r[6:0], serialIn.sda};
                  bitCnt_r <= bitCnt_r + 4'd1;
               end else if (byteDone) begin
                  bitCnt_r <= 4'd0;
                  if (byteIdx_r == 2'd0 && !addrMatch) begin
                     state_r <= S_IGNORE;
                  end else begin
                     state_r <= S_ACK;
                  end
               end
            end
            S_ACK: begin
               if (sclFall) begin
                  state_r <= S_RECV;
                  if (byteIdx_r != 2'd2) begin
                     byteIdx_r <= byteIdx_r + 2'd1;
                  end
               end
            end
            S_IDLE, S_IGNORE: begin
               state_r <= state_r;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   // The device only ever pulls the data line low, during its acknowledge.
   assign sdaOut = 1'b0;
   assign sdaOe  = (state_r == S_ACK);

   // Register pointer: loaded by the offset byte, advanced after each data byte.
   always_ff @(posedge clk) begin
      if (reset) begin
         ptr_r <= 8'h00;
      end else if (byteDone && byteIdx_r == 2'd1) begin
         ptr_r <= shift_r;
      end else if (wrStb) begin
         ptr_r <= ptr_r + 8'h01;
      end
   end

   // Global control registers.
   always_ff @(posedge clk) begin
      if (regClear) begin
         shutNormal_r <= 1'b0;
         gateOff_r    <= 1'b0;
         freqFast_r   <= 1'b0;
      end else if (wrStb) begin
         if (ptr_r == `OFF_SHUTDOWN) begin
            shutNormal_r <= shift_r[`BIT_D0];
         end
         if (ptr_r == `OFF_GATE) begin
            gateOff_r <= shift_r[`BIT_D0];
         end
         if (ptr_r == `OFF_FREQ) begin
            freqFast_r <= shift_r[`BIT_D0];
         end
      end
   end

   // PWM step divider and shared phase counter.
   assign tick = (divCnt_r == (freqFast_r ? FAST_DIV : SLOW_DIV) - 8'd1);
   always_ff @(posedge clk) begin
      if (regClear) begin
         divCnt_r <= 8'h00;
         phase_r  <= 8'h00;
      end else if (tick) begin
         divCnt_r <= 8'h00;
         phase_r  <= phase_r + 8'h01;
      end else begin
         divCnt_r <= divCnt_r + 8'h01;
      end
   end

   // Per-channel holding and active copies and the gated output.
   for (genvar i = 0; i < `CHANNELS; i++) begin : g_chan
      localparam logic [7:0] DUTY_OFF = 8'(`OFF_DUTY_BASE + i);
      localparam logic [7:0] CTRL_OFF = 8'(`OFF_CTRL_BASE + i);

      // Holding copies take the written bytes.
      always_ff @(posedge clk) begin
         if (regClear) begin
            holdDuty[i] <= `RESET_BYTE;
            holdCtrl[i] <= '0;
         end else if (wrStb) begin
            if (ptr_r == DUTY_OFF) begin
               holdDuty[i] <= shift_r;
            end
            if (ptr_r == CTRL_OFF) begin
               holdCtrl[i] <= shift_r[`CTRL_SCALE_HI:`CTRL_ON_BIT];
            end
         end
      end

      // Active copies change only on a commit write or a reset.
      always_ff @(posedge clk) begin
         if (regClear) begin
            actDuty[i] <= `RESET_BYTE;
            actCtrl[i] <= '0;
         end else if (commit) begin
            actDuty[i] <= holdDuty[i];
            actCtrl[i] <= holdCtrl[i];
         end
      end

      // Output conducts while running, gate open, on and within duty.
      assign chanOut_nxt[i] = shutNormal_r & ~gateOff_r & actCtrl[i].chanOn & (phase_r < actDuty[i]);

      assign chanScale[i] = actCtrl[i].currentScale;
   end

   // All channel outputs are registered in one process, so the vector has a single driver.
   always_ff @(posedge clk) begin
      if (regClear) begin
         chanOut <= '0;
      end else begin
         chanOut <= chanOut_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // Checks on the receiver, registers and outputs.
   a_ack_after_byte:  assert property (byteDone && byteIdx_r != 2'd0 |=> sdaOe)
      else $error("no acknowledge after a received byte");
   a_ignore_foreign:  assert property (byteDone && byteIdx_r == 2'd0 && !addrMatch |=> !sdaOe [*8])
      else $error("foreign address was acknowledged");
   a_ptr_advance:     assert property (wrStb && !swReset |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("pointer did not advance after data byte");
   a_commit_copies:   assert property (commit |=> actDuty[0] == $past(holdDuty[0]))
      else $error("commit did not copy held duty");
   a_hold_until_commit: assert property (!commit && !swReset |=> $stable(actDuty[27]) && $stable(actCtrl[27]))
      else $error("active copy changed without commit");
   a_shutdown_dark:   assert property (!shutNormal_r |=> chanOut == '0)
      else $error("output on during software shutdown");
   a_gate_dark:       assert property (gateOff_r |=> chanOut == '0)
      else $error("output on while global gate is off");
   a_duty_on:         assert property (shutNormal_r && !gateOff_r && actCtrl[0].chanOn && phase_r < actDuty[0]
                                       |=> chanOut[0])
      else $error("channel dark inside its duty window");
   a_zero_duty_dark:  assert property (actDuty[0] == 8'h00 |=> !chanOut[0])
      else $error("zero duty channel conducted");
   a_soft_reset:      assert property (swReset |=> !shutNormal_r && !freqFast_r && actDuty[0] == 8'h00)
      else $error("soft reset left a register set");
   a_tick_spacing:    assert property (tick |=> !tick [*8])
      else $error("PWM step enable too frequent");

   c_commit:     cover property (commit);
   c_soft_reset: cover property (swReset);
   c_burst:      cover property (wrStb ##[1:400] wrStb);
   c_lit:        cover property (chanOut[0] && freqFast_r);

endmodule

/* File: rtl/led_pwm_regs.svh */
`ifndef LED_PWM_REGS_SVH
`define LED_PWM_REGS_SVH

// Register offsets as seen on the serial port.
`define OFF_SHUTDOWN    8'h00
`define OFF_DUTY_BASE   8'h05
`define OFF_DUTY_LAST   8'h20
`define OFF_COMMIT      8'h25
`define OFF_CTRL_BASE   8'h2a
`define OFF_CTRL_LAST   8'h45
`define OFF_GATE        8'h4a
`define OFF_FREQ        8'h4b
`define OFF_SOFT_RESET  8'h4f

// Field positions and reset values.
`define BIT_D0          0
`define CTRL_ON_BIT     0
`define CTRL_SCALE_LO   1
`define CTRL_SCALE_HI   2
`define RESET_BYTE      8'h00
`define TRIGGER_BYTE    8'h00

// Serial slave address: fixed high bits, strap bits, write flag.
`define SLAVE_ADDR_HI   5'b01111
`define WRITE_FLAG      1'b0
`define CHANNELS        28

// Timing: one PWM period has 256 steps.
`define CLK_HZ          125000000
`define PWM_STEPS       256
`define PWM_SLOW_HZ     3000
`define PWM_FAST_HZ     22000
`define PWM_SLOW_DIV    (`CLK_HZ / (`PWM_SLOW_HZ * `PWM_STEPS))
`define PWM_FAST_DIV    (`CLK_HZ / (`PWM_FAST_HZ * `PWM_STEPS))

`endif

/* File: rtl/led_pwm_pkg.sv */
package led_pwm_pkg;

   // Per-channel control field: current scale and on bit.
   typedef struct packed {
      logic [1:0] currentScale;
      logic       chanOn;
   } chan_ctrl_t;

   // Serial pins as sampled by the device.
   typedef struct packed {
      logic scl;
      logic sda;
   } serial_in_t;

   // Serial receiver states, one-hot.
   typedef enum logic [3:0] {
      S_IDLE   = 4'b0001,
      S_RECV   = 4'b0010,
      S_ACK    = 4'b0100,
      S_IGNORE = 4'b1000
   } rx_state_t;

endpackage

/* File: verif/host_i2c_model.sv */
module host_i2c_model
   import led_pwm_pkg::*;
(
   // Clock and device answer.
   input  wire logic clk,
   input  wire logic sdaOe,
   input  wire logic sdaOut,
   // Pins seen by the device.
   output serial_in_t serialIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl    = 1'b1;
   logic sdaDrv = 1'b1;

   // The data line has a pull-up; while the device enables its driver the line shows what it drives.
   assign serialIn = '{scl: scl, sda: sdaDrv & (sdaOe ? sdaOut : 1'b1)};

   // Lets n edges pass, then steps just past the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Sends one framed transfer and returns one acknowledge bit per byte.
   task automatic xfer(input logic [7:0] b[$], output logic [7:0] acks);
      logic [8:0] sh;
      acks = '0;
      tick(4);
      sdaDrv = 1'b0;
      tick(4);
      scl = 1'b0;
      foreach (b[i]) begin
         sh = {b[i], 1'b1};
         for (int k = 8; k >= 0; k--) begin
            sdaDrv = sh[k];
            tick(4);
            scl = 1'b1;
            tick(2);
            if (k == 0) acks[i] = ~serialIn.sda;
            tick(2);
            scl = 1'b0;
         end
      end
      sdaDrv = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sdaDrv = 1'b1;
      tick(4);
   endtask
endmodule

/* File: verif/tb_led_pwm_register_bank.sv */
module tb_led_pwm_register_bank;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {int ch; logic [7:0] duty; logic [7:0] ctrl; logic [1:0] scale;} row_t;
   localparam int FAST = 22;
   localparam int SLOW = 162;
   logic                    clk       = 1'b0;
   logic                    reset     = 1'b1;
   logic [1:0]              addrStrap = 2'b10;
   led_pwm_pkg::serial_in_t serialIn;
   logic                    sdaOe;
   logic                    sdaOut;
   logic [27:0]             chanOut;
   logic [27:0][1:0]        chanScale;
   int                      nErrors     = 0;
   int                      comparisons = 0;
   int                      cnt;
   logic [7:0]              ack;
   row_t rows[4] = '{'{0, 8'h80, 8'h03, 2'b01}, '{1, 8'hff, 8'h07, 2'b11},
                     '{27, 8'h01, 8'h05, 2'b10}, '{5, 8'h40, 8'h00, 2'b00}};
   // Host-side gamma ramp of 32 steps, written and committed back to back.
   logic [7:0] gammaTable[32] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0a, 8'h0d, 8'h12, 8'h16, 8'h1c, 8'h21,
                                  8'h27, 8'h2e, 8'h35, 8'h3d, 8'h45, 8'h4e, 8'h56, 8'h60, 8'h6a, 8'h74, 8'h7e,
                                  8'h8a, 8'h95, 8'ha1, 8'had, 8'hba, 8'hc7, 8'hd4, 8'he2, 8'hf0, 8'hff};

   led_pwm_register_bank dut (.clk(clk), .reset(reset), .serialIn(serialIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
                              .addrStrap(addrStrap), .chanOut(chanOut), .chanScale(chanScale));
   host_i2c_model host (.clk(clk), .sdaOe(sdaOe), .sdaOut(sdaOut), .serialIn(serialIn));

   // Free-running clock.
   initial begin
      forever #4 clk = ~clk;
   end

   // Prints the counts and the verdict, then stops.
   task automatic close_out;
      $display("errors %0d comparisons %0d", nErrors, comparisons);
      if (nErrors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Compares any value with four-state equality.
   task automatic checkBits(input logic [127:0] got, input logic [127:0] exp);
      comparisons++;
      if (got !== exp) begin
         nErrors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Writes a burst at one offset and expects every byte acknowledged.
   task automatic wr(input logic [7:0] off, input logic [7:0] d[$]);
      host.xfer({8'h7c, off, d}, ack);
      checkBits(ack, (64'h1 << (d.size() + 2)) - 1);
   endtask

   // Counts the cycles in which one channel conducts.
   task automatic countHigh(input int ch, input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         c += (chanOut[ch] === 1'b1) ? 1 : ((chanOut[ch] === 1'b0) ? 0 : 1000000);
      end
   endtask

   // Main sequence: table of channel setups, then the awkward cases.
   initial begin
      repeat (5) @(posedge clk);
      #1;
      reset = 1'b0;
      checkBits({chanOut, chanScale}, 0);
      wr(8'h00, {8'h01});
      wr(8'h4a, {8'h00, 8'h01});
      foreach (rows[i]) begin
         wr(8'(42 + rows[i].ch), {rows[i].ctrl});
         wr(8'(5 + rows[i].ch), {rows[i].duty});
         checkBits(chanScale[rows[i].ch], 0);
         wr(8'h25, {8'h00});
         checkBits(chanScale[rows[i].ch], rows[i].scale);
         countHigh(rows[i].ch, 256 * FAST, cnt);
         checkBits(cnt, rows[i].ctrl[0] ? rows[i].duty * FAST : 0);
      end
      // Burst through unmapped offsets ends in a commit.
      wr(8'h20, {8'h10, 8'hab, 8'hab, 8'hab, 8'hab, 8'h00});
      countHigh(27, 256 * FAST, cnt);
      checkBits(cnt, 16 * FAST);
      // A commit with non-zero data must not take effect.
      wr(8'h05, {8'h20});
      wr(8'h25, {8'h01});
      countHigh(0, 256 * FAST, cnt);
      checkBits(cnt, 128 * FAST);
      wr(8'h4a, {8'h01});
      countHigh(1, 600, cnt);
      checkBits(cnt, 0);
      wr(8'h4a, {8'h00});
      wr(8'h00, {8'h00});
      countHigh(1, 600, cnt);
      checkBits(cnt, 0);
      wr(8'h00, {8'h01});
      // Breathing ramp on channel two: each gamma step is written, then committed.
      foreach (gammaTable[i]) begin
         wr(8'h06, {gammaTable[i]});
         wr(8'h25, {8'h00});
         if (i == 0) begin
            countHigh(1, 600, cnt);
            checkBits(cnt, 0);
         end
      end
      wr(8'h4b, {8'h00});
      countHigh(1, 256 * SLOW, cnt);
      checkBits(cnt, 255 * SLOW);
      host.xfer({8'h7e, 8'h4a, 8'h01}, ack);
      checkBits(ack, 0);
      host.xfer({8'h7d, 8'h4a, 8'h01}, ack);
      checkBits(ack, 0);
      wr(8'h4f, {8'h00});
      checkBits(chanScale, 0);
      wr(8'h00, {8'h01});
      wr(8'h25, {8'h00});
      countHigh(1, 600, cnt);
      checkBits(cnt, 0);
      close_out();
   end

   // Cuts a hang short.
   initial begin
      repeat (105000) @(posedge clk);
      nErrors++;
      close_out();
   end
endmodule
